// ===== hdl/ddmas_pkg.sv
// Package with register map, field positions and types for the DMA slave
package ddmas_pkg;
  localparam logic [3:0]  DDMAS_OFS_ADDR      = 4'h0;
  localparam logic [3:0]  DDMAS_OFS_PAGE      = 4'h2;
  localparam logic [3:0]  DDMAS_OFS_COUNT     = 4'h4;
  localparam logic [3:0]  DDMAS_OFS_CMDSTAT   = 4'h8;
  localparam logic [7:0]  DDMAS_CFG_BASE_OFS  = 8'h98;
  localparam int          DDMAS_CMD_DIS_BIT   = 2;
  localparam logic [15:0] DDMAS_RST_ADDR      = 16'h0000;
  localparam logic [7:0]  DDMAS_RST_PAGE      = 8'h00;
  localparam logic [15:0] DDMAS_RST_COUNT     = 16'h0000;
  localparam logic [7:0]  DDMAS_RST_CMD       = 8'h00;
  localparam logic [7:0]  DDMAS_RST_STAT      = 8'h00;
  localparam logic [15:0] DDMAS_STEP_8        = 16'h0001;
  localparam logic [15:0] DDMAS_STEP_16       = 16'h0002;

  typedef struct packed {
    logic        wr;
    logic [3:0]  ofs;
    logic [15:0] data;
  } ddmas_req_t;

  typedef enum logic [1:0] {
    DDMAS_IDLE = 2'b00,
    DDMAS_ADDR = 2'b01,
    DDMAS_DATA = 2'b10
  } ddmas_state_t;
endpackage

// ===== hdl/ddmas_fifo.sv
// Request queue module is kept in ddmas_top.sv beside its only user

// ===== hdl/ddmas_top.sv
// Distributed DMA slave register set and address-phase generator
module ddmas_top #(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic [31:0]         io_base,
  input  wire logic                io_valid,
  output logic                     io_ready,
  input  wire logic [31:0]         io_addr,
  input  wire logic                io_wr,
  input  wire logic [15:0]         io_wdata,
  output logic                     rd_valid,
  output logic [15:0]              rd_data,
  input  wire logic                mode_16bit,
  input  wire logic                xfer_done,
  input  wire logic                card_dma_request,
  output logic [31:0]              ad_addr,
  output logic                     controller_disable_bit,
  output logic                     terminal_count_flag
);
  import ddmas_pkg::*;

  localparam int RW = $bits(ddmas_req_t);

  logic        card_dma_request_s1_r;
  logic        card_dma_request_s2_r;
  logic [15:0] base_addr_r;
  logic [15:0] cur_addr_r;
  logic [7:0]  page_r;
  logic [15:0] base_cnt_r;
  logic [15:0] cur_cnt_r;
  logic [7:0]  cmd_r;
  logic [3:0]  tc_r;
  logic [15:0] rd_data_r;
  logic        rd_valid_r;
  logic [31:0] ad_addr_r;

  // Address hit in the 16-byte window
  wire         win_hit = (io_addr[31:4] == io_base[31:4]);
  ddmas_req_t  in_req;
  ddmas_req_t  q_req;
  wire         q_valid;
  wire         q_ready = 1'b1;
  assign in_req.wr   = io_wr;
  assign in_req.ofs  = io_addr[3:0];
  assign in_req.data = io_wdata;

  logic        fifo_in_ready;
  assign io_ready = fifo_in_ready;

  ddmas_fifo #(.WIDTH(RW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (io_valid && win_hit),
    .in_ready  (fifo_in_ready),
    .in_data   (in_req),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_req)
  );

  wire acc     = q_valid && q_ready;
  wire wr_addr = acc && q_req.wr && (q_req.ofs == DDMAS_OFS_ADDR);
  wire wr_page = acc && q_req.wr && (q_req.ofs == DDMAS_OFS_PAGE);
  wire wr_cnt  = acc && q_req.wr && (q_req.ofs == DDMAS_OFS_COUNT);
  wire wr_cmd  = acc && q_req.wr && (q_req.ofs == DDMAS_OFS_CMDSTAT);
  wire rd_acc  = acc && !q_req.wr;
  wire rd_stat = rd_acc && (q_req.ofs == DDMAS_OFS_CMDSTAT);

  wire         enabled = !cmd_r[DDMAS_CMD_DIS_BIT];
  wire         step_ok = xfer_done && enabled;
  wire [15:0]  step    = mode_16bit ? DDMAS_STEP_16 : DDMAS_STEP_8;
  wire         at_tc   = step_ok && (cur_cnt_r <= step);
  wire [7:0]   status  = {{4{card_dma_request_s2_r}}, tc_r};

  // Read mux; unmapped offsets return zero
  wire [15:0] rd_mux =
    (q_req.ofs == DDMAS_OFS_ADDR)    ? cur_addr_r :
    (q_req.ofs == DDMAS_OFS_PAGE)    ? {8'h00, page_r} :
    (q_req.ofs == DDMAS_OFS_COUNT)   ? cur_cnt_r :
    (q_req.ofs == DDMAS_OFS_CMDSTAT) ? {8'h00, status} :
                                       16'h0000;

  // Offsets that hold a register; all others are reserved
  wire ofs_mapped = (q_req.ofs == DDMAS_OFS_ADDR)
                 || (q_req.ofs == DDMAS_OFS_PAGE)
                 || (q_req.ofs == DDMAS_OFS_COUNT)
                 || (q_req.ofs == DDMAS_OFS_CMDSTAT);

  // Address phase layout per transfer width
  wire [31:0] ad_nxt = mode_16bit ?
    {8'h00, page_r[7:1], cur_addr_r, 1'b0} :
    {8'h00, page_r, cur_addr_r};

  always_ff @(posedge clk) begin
    if (rst) begin
      card_dma_request_s1_r <= 1'b0;
      card_dma_request_s2_r <= 1'b0;
    end else if (ce) begin
      card_dma_request_s1_r <= card_dma_request;
      card_dma_request_s2_r <= card_dma_request_s1_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      base_addr_r <= DDMAS_RST_ADDR;
      cur_addr_r  <= DDMAS_RST_ADDR;
    end else if (ce) begin
      if (wr_addr) begin
        base_addr_r <= q_req.data;
        cur_addr_r  <= q_req.data;
      end else if (step_ok)
        cur_addr_r <= cur_addr_r + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
      page_r <= DDMAS_RST_PAGE;
    else if (ce && wr_page)
      page_r <= q_req.data[7:0];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      base_cnt_r <= DDMAS_RST_COUNT;
      cur_cnt_r  <= DDMAS_RST_COUNT;
    end else if (ce) begin
      if (wr_cnt) begin
        base_cnt_r <= q_req.data;
        cur_cnt_r  <= q_req.data;
      end else if (step_ok)
        cur_cnt_r <= at_tc ? 16'h0000 : cur_cnt_r - step;
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
      cmd_r <= DDMAS_RST_CMD;
    else if (ce && wr_cmd)
      cmd_r <= {5'h00, q_req.data[DDMAS_CMD_DIS_BIT], 2'h0};
  end

  // Terminal count set wins over clear on read
  always_ff @(posedge clk) begin
    if (rst)
      tc_r <= DDMAS_RST_STAT[3:0];
    else if (ce) begin
      if (at_tc)
        tc_r <= 4'hf;
      else if (rd_stat)
        tc_r <= 4'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_r  <= 16'h0000;
      rd_valid_r <= 1'b0;
      ad_addr_r  <= 32'h0000_0000;
    end else if (ce) begin
      rd_valid_r <= rd_acc;
      if (rd_acc)
        rd_data_r <= rd_mux;
      ad_addr_r <= ad_nxt;
    end
  end

  assign rd_data                = rd_data_r;
  assign rd_valid               = rd_valid_r;
  assign ad_addr                = ad_addr_r;
  assign controller_disable_bit = cmd_r[DDMAS_CMD_DIS_BIT];
  assign terminal_count_flag    = tc_r[0];

  // Checks on register, status and address-phase behaviour
  cmd_reserved_a: assert property (@(posedge clk) disable iff (rst)
    cmd_r[7:3] == 5'h00 && cmd_r[1:0] == 2'h0)
    else $error("command reserved bits set");

  tc_set_a: assert property (@(posedge clk) disable iff (rst)
    ce && at_tc |=> tc_r == 4'hf)
    else $error("terminal count not flagged");

  tc_clear_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd_stat && !at_tc |=> tc_r == 4'h0)
    else $error("status read did not clear");

  tc_hold_a: assert property (@(posedge clk) disable iff (rst)
    ce && tc_r == 4'hf && !rd_stat |=> tc_r == 4'hf)
    else $error("terminal count lost before read");

  status_write_a: assert property (@(posedge clk) disable iff (rst)
    ce && wr_cmd && !at_tc |=> tc_r == $past(tc_r))
    else $error("command write disturbed status");

  addr_load_a: assert property (@(posedge clk) disable iff (rst)
    ce && wr_addr |=> cur_addr_r == $past(q_req.data)
      && base_addr_r == cur_addr_r)
    else $error("address load wrong");

  cnt_load_a: assert property (@(posedge clk) disable iff (rst)
    ce && wr_cnt |=> cur_cnt_r == $past(q_req.data)
      && base_cnt_r == cur_cnt_r)
    else $error("count load wrong");

  page_load_a: assert property (@(posedge clk) disable iff (rst)
    ce && wr_page |=> page_r == $past(q_req.data[7:0]))
    else $error("page load wrong");

  cnt_step_a: assert property (@(posedge clk) disable iff (rst)
    ce && step_ok && !wr_cnt && !at_tc |=>
      cur_cnt_r == $past(cur_cnt_r)
        - ($past(mode_16bit) ? DDMAS_STEP_16 : DDMAS_STEP_8))
    else $error("count step wrong");

  ad_16_a: assert property (@(posedge clk) disable iff (rst)
    ce && mode_16bit |=> ad_addr[0] == 1'b0
      && ad_addr[16:1] == $past(cur_addr_r))
    else $error("16-bit address phase wrong");

  ad_page16_a: assert property (@(posedge clk) disable iff (rst)
    ce && mode_16bit |=> ad_addr[23:17] == $past(page_r[7:1])
      && ad_addr[31:24] == 8'h00)
    else $error("16-bit page phase wrong");

  ad_8_a: assert property (@(posedge clk) disable iff (rst)
    ce && !mode_16bit |=> ad_addr[23:0] == {$past(page_r), $past(cur_addr_r)})
    else $error("8-bit address phase wrong");

  card_dma_request_stat_a: assert property (@(posedge clk) disable iff (rst)
    ce && $past(ce) && !$past(rst) |=>
      status[7:4] == {4{$past(card_dma_request, 2)}})
    else $error("request status mismatch");

  rd_status_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd_stat |=> rd_valid
      && rd_data == {8'h00, {4{$past(card_dma_request_s2_r)}}, $past(tc_r)})
    else $error("status read data wrong");

  rd_reserved_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd_acc && !ofs_mapped |=> rd_data == 16'h0000)
    else $error("reserved offset read not zero");

  ce_freeze_a: assert property (@(posedge clk) disable iff (rst)
    !ce |=> cur_cnt_r == $past(cur_cnt_r) && cur_addr_r == $past(cur_addr_r)
      && tc_r == $past(tc_r) && rd_valid == $past(rd_valid))
    else $error("state moved while clock enable low");

  disable_stops_a: assert property (@(posedge clk) disable iff (rst)
    ce && !enabled && !wr_cnt |=> cur_cnt_r == $past(cur_cnt_r))
    else $error("disabled controller counted");
endmodule

// Small synchronous FIFO with valid/ready on both sides
module ddmas_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r        <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + AW'(1);
      end
      if (pop)
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + AW'(1);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== tb/ddmas_dma_master.sv
// Central DMA master model that reports completed transfers
module ddmas_dma_master (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [3:0] n,
  output logic            xfer_done,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left_r;
  assign busy = (left_r != 4'h0);
  initial begin
    xfer_done = 1'b0;
    left_r = 4'h0;
  end
  // One done pulse every other cycle, changed off the sampling edge
  always @(negedge clk) begin
    if (start) begin
      left_r <= n;
    end else if (xfer_done) begin
      xfer_done <= 1'b0;
    end else if (busy) begin
      xfer_done <= 1'b1;
      left_r <= left_r - 4'h1;
    end
  end
endmodule

// ===== tb/ddmas_top_test.sv
// Self-checking bench for the DMA slave register set
module test_ddmas_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ddmas_pkg::*;
  localparam logic [31:0] B = 32'h0000_1000;
  logic clk, rst, io_valid, io_ready, io_wr, rd_valid, mode_16bit, go, busy;
  logic xfer_done, card_dma_request, controller_disable_bit, tcf, ce;
  logic [31:0] io_addr, ad_addr;
  logic [15:0] io_wdata, rd_data, got;
  logic [3:0]  n_xfer;
  int          fails, n_checks;
  ddmas_top uut (.clk(clk), .rst(rst), .ce(ce), .io_base(B),
    .io_valid(io_valid), .io_ready(io_ready), .io_addr(io_addr),
    .io_wr(io_wr), .io_wdata(io_wdata), .rd_valid(rd_valid),
    .rd_data(rd_data), .mode_16bit(mode_16bit), .xfer_done(xfer_done),
    .card_dma_request(card_dma_request), .ad_addr(ad_addr),
    .controller_disable_bit(controller_disable_bit),
    .terminal_count_flag(tcf));
  ddmas_dma_master master (.clk(clk), .start(go), .n(n_xfer),
    .xfer_done(xfer_done), .busy(busy));
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] o, input logic [15:0] d,
                     input logic [31:0] b = B);
    @(negedge clk);
    io_valid = 1'b1;
    io_wr = w;
    io_addr = b | {28'h0, o};
    io_wdata = d;
    for (int i = 0; i < 20 && io_ready !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    io_valid = 1'b0;
  endtask
  task automatic wr(input logic [3:0] o, input logic [15:0] d);
    acc(1'b1, o, d);
    repeat (3) @(negedge clk);
  endtask
  task automatic rd(input logic [3:0] o);
    acc(1'b0, o, 16'h0);
    got = 16'hxxxx;
    for (int i = 0; i < 8; i++) begin
      if (rd_valid === 1'b1) begin
        got = rd_data;
        break;
      end
      @(negedge clk);
    end
  endtask
  task automatic run(input logic [3:0] n);
    @(negedge clk);
    n_xfer <= n;
    go <= 1'b1;
    @(negedge clk);
    go <= 1'b0;
    @(negedge clk);
    for (int i = 0; i < 40 && busy; i++) @(negedge clk);
    repeat (4) @(negedge clk);
  endtask
  task automatic t_reset;
    chk("ready", 1'b1, io_ready);
    chk("ad", 32'h0, ad_addr);
    chk("tcflag", 1'b0, tcf);
    rd(4'h0);
    chk("addr", 16'h0, got);
    rd(4'h2);
    chk("page", 16'h0, got);
    rd(4'h4);
    chk("count", 16'h0, got);
    rd(4'h8);
    chk("status", 16'h0, got);
    chk("disable", 1'b0, controller_disable_bit);
  endtask
  task automatic t_regs;
    wr(4'h0, 16'h1234);
    wr(4'h2, 16'h00a5);
    wr(4'h4, 16'h0003);
    wr(4'h6, 16'hffff);
    acc(1'b1, 4'h0, 16'hbeef, 32'h0000_2000);
    repeat (3) @(negedge clk);
    rd(4'h0);
    chk("addr", 16'h1234, got);
    rd(4'h2);
    chk("page", 16'h00a5, got);
    rd(4'h4);
    chk("count", 16'h0003, got);
    rd(4'h6);
    chk("reserved", 16'h0, got);
  endtask
  task automatic t_adphase;
    chk("ad8", 32'h00a5_1234, ad_addr);
    mode_16bit = 1'b1;
    repeat (3) @(negedge clk);
    chk("ad16", 32'h00a4_2468, ad_addr);
    mode_16bit = 1'b0;
  endtask
  task automatic t_xfer;
    run(4'h1);
    rd(4'h0);
    chk("addr", 16'h1235, got);
    rd(4'h4);
    chk("count", 16'h0002, got);
    chk("ad", 32'h00a5_1235, ad_addr);
    mode_16bit = 1'b1;
    run(4'h1);
    rd(4'h4);
    chk("count", 16'h0000, got);
    chk("tcflag", 1'b1, tcf);
    rd(4'h8);
    chk("status", 16'h000f, got);
    rd(4'h8);
    chk("status", 16'h0000, got);
    chk("tcflag", 1'b0, tcf);
    wr(4'h4, 16'h0006);
    run(4'h1);
    rd(4'h4);
    chk("count", 16'h0004, got);
    rd(4'h0);
    chk("addr", 16'h1237, got);
    chk("ad16", 32'h00a4_246e, ad_addr);
    mode_16bit = 1'b0;
  endtask
  task automatic t_disable;
    wr(4'h8, 16'hffff);
    chk("disable", 1'b1, controller_disable_bit);
    wr(4'h4, 16'h0005);
    run(4'h2);
    rd(4'h4);
    chk("count", 16'h0005, got);
    rd(4'h8);
    chk("status", 16'h0000, got);
    wr(4'h8, 16'h0000);
    chk("disable", 1'b0, controller_disable_bit);
  endtask
  task automatic t_freeze;
    ce = 1'b0;
    run(4'h1);
    ce = 1'b1;
    rd(4'h4);
    chk("count", 16'h0005, got);
    run(4'h1);
    rd(4'h4);
    chk("count", 16'h0004, got);
  endtask
  task automatic t_request;
    card_dma_request = 1'b1;
    repeat (4) @(negedge clk);
    rd(4'h8);
    chk("status", 16'h00f0, got);
    card_dma_request = 1'b0;
    repeat (4) @(negedge clk);
    rd(4'h8);
    chk("status", 16'h0000, got);
  endtask
  task automatic summarize;
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(3000 * 25);
    fails++;
    summarize();
  end
  initial begin
    {rst, ce, io_valid, io_wr, mode_16bit, go, card_dma_request} = 7'h60;
    io_addr = 32'h0;
    io_wdata = 16'h0;
    n_xfer = 4'h0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_adphase();
    t_xfer();
    t_disable();
    t_freeze();
    t_request();
    summarize();
  end
endmodule
